// ==== design/cmr_hit_filter.sv ====
// Blanking window and consecutive-sample filter on the comparator.
// Assumes comparator input already gated and synchronous to pclk.
`timescale 1ns/1ns
module cmr_hit_filter
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Timing
    input wire logic base_tick,
    input wire logic sample_en,
    input wire logic pwm_rise,
    // Configuration
    input wire logic [2:0] blanking_length,
    input wire logic [2:0] feedback_hit_count,
    // Comparator
    input wire logic comp_in,
    // Results
    output logic blanking,
    output logic limit_evt,
    output logic [3:0] hit_cnt
);
    import cmr_pkg::*;

    logic [4:0] blank_q;
    logic [3:0] hit_q;
    logic evt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            blank_q <= 5'h00;
        else if (pwm_rise)
            blank_q <= 5'(blanking_length * BLANK_STEP_TICKS);
        else if (base_tick && blank_q != 5'h00)
            blank_q <= blank_q - 5'h01;
    end

    assign blanking = (blank_q != 5'h00) ||
                      (pwm_rise && blanking_length != 3'h0);

    // Counter saturates at feedback_hit_count plus one so a held limit keeps firing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hit_q <= 4'h0;
        else if (blanking)
            hit_q <= 4'h0;
        else if (sample_en && !comp_in)
            hit_q <= 4'h0;
        else if (sample_en && hit_q <= {1'b0, feedback_hit_count})
            hit_q <= hit_q + 4'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt_q <= 1'b0;
        else
            evt_q <= sample_en && comp_in && !blanking &&
                     (hit_q >= {1'b0, feedback_hit_count});
    end

    assign limit_evt = evt_q;
    assign hit_cnt = hit_q;

endmodule : cmr_hit_filter

// ==== design/cmr_pkg.sv ====
// Constants, field layout and types of the current-mode PWM regulator.
// Assumes pclk at 20 MHz; peripheral clock rates are derived from it.
package cmr_pkg;

    // Clock rates
    localparam int unsigned PCLK_HZ = 20_000_000;
    localparam int unsigned BASE_HZ = 4_000_000;
    localparam int unsigned BASE_DIV = PCLK_HZ / BASE_HZ;

    // Peripheral clock phase accumulator, in MHz units
    localparam int unsigned PER_MOD = PCLK_HZ / 1_000_000;
    localparam int unsigned PER_STEP_SLOW = 4;
    localparam int unsigned PER_STEP_FAST = 8;
    localparam int unsigned PER_AW = 5;
    localparam int unsigned SAMPLE_DIV = 4;

    // Durations, in ns, and their count in 4 MHz base ticks
    localparam int unsigned BLANK_STEP_NS = 500;
    localparam int unsigned OFF_STEP_NS = 2500;
    localparam int unsigned BLANK_STEP_TICKS =
        (BLANK_STEP_NS * (BASE_HZ / 1000) + 999_999) / 1_000_000;
    localparam int unsigned OFF_STEP_TICKS =
        (OFF_STEP_NS * (BASE_HZ / 1000) + 999_999) / 1_000_000;

    localparam int unsigned TW = 14;
    typedef logic [TW-1:0] cmr_ticks_t;

    // APB register byte offsets
    localparam int unsigned APB_AW = 8;
    localparam logic [7:0] OFS_FILTER = 8'h00;
    localparam logic [7:0] OFS_CTRL_A = 8'h04;
    localparam logic [7:0] OFS_AMP = 8'h08;
    localparam logic [7:0] OFS_REF = 8'h0C;
    localparam logic [7:0] OFS_PRESC = 8'h10;
    localparam logic [7:0] OFS_PWM_EN = 8'h14;
    localparam logic [7:0] OFS_CTRL_C = 8'h18;
    localparam logic [7:0] OFS_CONFIG = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;

    // Field positions
    localparam int unsigned FLT_BLANK_LSB = 0;
    localparam int unsigned FLT_HIT_LSB = 4;
    localparam int unsigned CRA_CLK_EN = 0;
    localparam int unsigned CRA_DIRECT = 1;
    localparam int unsigned CRA_VC_SEL = 2;
    localparam int unsigned AMP_EN_BIT = 0;
    localparam int unsigned REF_SEL_BIT = 0;
    localparam int unsigned CRC_SENSOR = 0;
    localparam int unsigned CRC_ONZ = 1;
    localparam int unsigned CFG_DELAY_LSB = 0;
    localparam int unsigned CFG_LO_BIT = 4;
    localparam int unsigned CFG_HI_BIT = 5;
    localparam int unsigned ST_PWM = 0;
    localparam int unsigned ST_BLANK = 1;
    localparam int unsigned ST_LIMIT = 2;
    localparam int unsigned ST_FULL = 3;
    localparam int unsigned ST_HIT_LSB = 4;

    // Reset values
    localparam logic [2:0] RST_BLANK = 3'h0;
    localparam logic [2:0] RST_HIT = 3'h0;

    typedef enum logic [1:0]
    {
        CMR_S_WIN = 2'h0,
        CMR_S_ON = 2'h1,
        CMR_S_LIMIT = 2'h3
    } cmr_state_e;

    // Window period in base ticks for each frequency code
    function automatic cmr_ticks_t cmr_win_period(input logic [3:0] sel);
        case (sel)
            4'h0: return 14'h0050;
            4'h1: return 14'h0064;
            4'h2: return 14'h0078;
            4'h3: return 14'h00A0;
            4'h4: return 14'h00C8;
            4'h5: return 14'h00DD;
            4'h6: return 14'h0104;
            4'h7: return 14'h0140;
            4'h8: return 14'h0190;
            4'h9: return 14'h0280;
            4'hA: return 14'h04FE;
            4'hB: return 14'h0A04;
            4'hC: return 14'h0C80;
            4'hD: return 14'h1042;
            4'hE: return 14'h1900;
            default: return 14'h2810;
        endcase
    endfunction : cmr_win_period

endpackage : cmr_pkg

// ==== design/cmr_regulator.sv ====
// Current-mode PWM regulator: APB registers, window and PWM state.
// Assumes an APB master on pclk and comparator results synchronous.
// Overview of operation
// - Blanking masks comparator, 0.5 us per code step, code 0 off.
// - Blanking restarts at each PWM turn-on.
// - Blanking length resets to zero, blanking disabled.
// - Limit event after code plus one consecutive high samples.
// - After reset one sample raises the limit event.
// - Comparator sampled at a quarter of the peripheral clock.
// - On-time from window end to next window start or limit.
// - Comparator inactive until clock enable or direct access set.
// - Select 0 takes amplifier output, 1 the direct feedback pin.
// - Window frequency from 4-bit selector, 50 kHz down to 390 Hz.
// - Sensorless off-time minimum is 2.5 us times code plus one.
// - Outside sensor mode, window start also strobes back-EMF zero-crossing sampling.
// - Sensor mode, on-time sampling or a nonzero zero delay field: no minimum off time.
// - Off time beyond the period gives output constantly high.
// - Peripheral clock is 4 MHz, or 8 MHz by config bit 5.
// - Current mode PWM combines window and comparator outputs.
// - Select 0 passes voltage-mode PWM, 1 uses current mode.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module cmr_regulator
#(
    parameter int unsigned TICK_DIV = cmr_pkg::BASE_DIV
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cmr_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Comparator results and voltage-mode PWM
    input wire logic comp_amp_hi,
    input wire logic comp_direct_hi,
    input wire logic voltage_pwm_in,
    // To channel manager and analog front end
    output logic drive_pwm,
    output logic current_limit_event,
    output logic zero_sample_strobe,
    output logic amp_enable,
    output logic comparator_input_select
);
    import cmr_pkg::*;

    // Configuration registers
    logic [2:0] blanking_length_q;
    logic [2:0] feedback_hit_count_q;
    logic clk_en_q;
    logic direct_access_q;
    logic voltage_current_select_q;
    logic amp_enable_q;
    logic comparator_input_select_q;
    logic [3:0] window_freq_sel_q;
    logic [3:0] min_off_time_sel_q;
    logic sensor_mode_sel_q;
    logic on_time_zero_detect_q;
    logic [3:0] zero_delay_field_q;
    logic clock_div_hi_sel_q;
    logic clock_div_lo_sel_q;
    logic limit_seen_q;
    logic [31:0] prdata_q;

    // Bus decode
    logic wr_en;
    logic rd_setup;
    logic addr_hit;
    logic [31:0] rd_data;

    // Timing and PWM
    logic base_tick;
    logic sample_en;
    logic comp_raw;
    logic comp_act;
    logic blanking;
    logic limit_evt;
    logic [3:0] hit_cnt;
    cmr_ticks_t period;
    cmr_ticks_t off_len;
    cmr_ticks_t per_q;
    logic per_wrap;
    logic no_min_off;
    logic full_duty;
    cmr_state_e state_q;
    cmr_state_e state_d;
    logic pwm_d;
    logic pwm_q;
    logic zstrobe_q;

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite && pstrb[0];
    assign rd_setup = psel && !penable && !pwrite;

    always_comb
    begin
        addr_hit = 1'b1;
        rd_data = 32'h0000_0000;
        case (paddr)
            OFS_FILTER:
            begin
                rd_data[FLT_BLANK_LSB +: 3] = blanking_length_q;
                rd_data[FLT_HIT_LSB +: 3] = feedback_hit_count_q;
            end
            OFS_CTRL_A:
            begin
                rd_data[CRA_CLK_EN] = clk_en_q;
                rd_data[CRA_DIRECT] = direct_access_q;
                rd_data[CRA_VC_SEL] = voltage_current_select_q;
            end
            OFS_AMP: rd_data[AMP_EN_BIT] = amp_enable_q;
            OFS_REF: rd_data[REF_SEL_BIT] = comparator_input_select_q;
            OFS_PRESC: rd_data[3:0] = window_freq_sel_q;
            OFS_PWM_EN: rd_data[3:0] = min_off_time_sel_q;
            OFS_CTRL_C:
            begin
                rd_data[CRC_SENSOR] = sensor_mode_sel_q;
                rd_data[CRC_ONZ] = on_time_zero_detect_q;
            end
            OFS_CONFIG:
            begin
                rd_data[CFG_DELAY_LSB +: 4] = zero_delay_field_q;
                rd_data[CFG_LO_BIT] = clock_div_lo_sel_q;
                rd_data[CFG_HI_BIT] = clock_div_hi_sel_q;
            end
            OFS_STATUS:
            begin
                rd_data[ST_PWM] = pwm_q;
                rd_data[ST_BLANK] = blanking;
                rd_data[ST_LIMIT] = limit_seen_q;
                rd_data[ST_FULL] = full_duty;
                rd_data[ST_HIT_LSB +: 4] = hit_cnt;
            end
            default: addr_hit = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !addr_hit;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (rd_setup)
            prdata_q <= rd_data;
    end

    assign prdata = prdata_q;

    // Filter register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            blanking_length_q <= RST_BLANK;
            feedback_hit_count_q <= RST_HIT;
        end
        else if (wr_en && paddr == OFS_FILTER)
        begin
            blanking_length_q <= pwdata[FLT_BLANK_LSB +: 3];
            feedback_hit_count_q <= pwdata[FLT_HIT_LSB +: 3];
        end
    end

    // Control register A
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_en_q <= 1'b0;
            direct_access_q <= 1'b0;
            voltage_current_select_q <= 1'b0;
        end
        else if (wr_en && paddr == OFS_CTRL_A)
        begin
            clk_en_q <= pwdata[CRA_CLK_EN];
            direct_access_q <= pwdata[CRA_DIRECT];
            voltage_current_select_q <= pwdata[CRA_VC_SEL];
        end
    end

    // Analog front end selection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            amp_enable_q <= 1'b0;
            comparator_input_select_q <= 1'b0;
        end
        else if (wr_en && paddr == OFS_AMP)
            amp_enable_q <= pwdata[AMP_EN_BIT];
        else if (wr_en && paddr == OFS_REF)
            comparator_input_select_q <= pwdata[REF_SEL_BIT];
    end

    // Window and off-time selectors
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            window_freq_sel_q <= 4'h0;
            min_off_time_sel_q <= 4'h0;
        end
        else if (wr_en && paddr == OFS_PRESC)
            window_freq_sel_q <= pwdata[3:0];
        else if (wr_en && paddr == OFS_PWM_EN)
            min_off_time_sel_q <= pwdata[3:0];
    end

    // Mode and clock configuration
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sensor_mode_sel_q <= 1'b0;
            on_time_zero_detect_q <= 1'b0;
            zero_delay_field_q <= 4'h0;
            clock_div_hi_sel_q <= 1'b0;
            clock_div_lo_sel_q <= 1'b0;
        end
        else if (wr_en && paddr == OFS_CTRL_C)
        begin
            sensor_mode_sel_q <= pwdata[CRC_SENSOR];
            on_time_zero_detect_q <= pwdata[CRC_ONZ];
        end
        else if (wr_en && paddr == OFS_CONFIG)
        begin
            zero_delay_field_q <= pwdata[CFG_DELAY_LSB +: 4];
            clock_div_hi_sel_q <= pwdata[CFG_HI_BIT];
            clock_div_lo_sel_q <= pwdata[CFG_LO_BIT];
        end
    end

    // Sticky limit flag, write one to clear; a new event wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            limit_seen_q <= 1'b0;
        else if (limit_evt)
            limit_seen_q <= 1'b1;
        else if (wr_en && paddr == OFS_STATUS && pwdata[ST_LIMIT])
            limit_seen_q <= 1'b0;
    end

    cmr_tick_gen #(
        .TICK_DIV(TICK_DIV)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .fast_sel(clock_div_hi_sel_q),
        .base_tick(base_tick),
        .sample_en(sample_en)
    );

    // Comparator source and power gating
    assign comp_raw = comparator_input_select_q ? comp_direct_hi
                                                : comp_amp_hi;
    assign comp_act = (clk_en_q || direct_access_q) && comp_raw;

    cmr_hit_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .base_tick(base_tick),
        .sample_en(sample_en),
        .pwm_rise(pwm_d && !pwm_q),
        .blanking_length(blanking_length_q),
        .feedback_hit_count(feedback_hit_count_q),
        .comp_in(comp_act),
        .blanking(blanking),
        .limit_evt(limit_evt),
        .hit_cnt(hit_cnt)
    );

    // Window geometry
    assign period = cmr_win_period(window_freq_sel_q);
    assign no_min_off = sensor_mode_sel_q || on_time_zero_detect_q ||
                        (zero_delay_field_q != 4'h0);
    assign off_len = no_min_off ? '0 :
        cmr_ticks_t'(OFF_STEP_TICKS * (32'(min_off_time_sel_q) + 1));
    assign full_duty = (off_len > period);
    assign per_wrap = base_tick && (per_q == period - cmr_ticks_t'(1));

    // Period counter runs only with the peripheral clock enabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            per_q <= '0;
        else if (!clk_en_q)
            per_q <= '0;
        else if (per_wrap || per_q >= period)
            per_q <= '0;
        else if (base_tick)
            per_q <= per_q + cmr_ticks_t'(1);
    end

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            CMR_S_WIN:
            begin
                if (off_len == '0)
                    state_d = CMR_S_ON;
                else if (base_tick && per_q == off_len - cmr_ticks_t'(1))
                    state_d = CMR_S_ON;
            end
            CMR_S_ON:
            begin
                if (per_wrap)
                    state_d = (off_len == '0) ? CMR_S_ON : CMR_S_WIN;
                if (limit_evt)
                    state_d = CMR_S_LIMIT;
            end
            CMR_S_LIMIT:
            begin
                if (per_wrap)
                    state_d = CMR_S_WIN;
            end
            default: state_d = CMR_S_WIN;
        endcase
        if (!clk_en_q)
            state_d = CMR_S_WIN;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= CMR_S_WIN;
        else
            state_q <= state_d;
    end

    // Output select; the limit in voltage mode is left to the channel side
    always_comb
    begin
        if (!voltage_current_select_q)
            pwm_d = voltage_pwm_in;
        else if (full_duty && clk_en_q)
            pwm_d = 1'b1;
        else
            pwm_d = (state_d == CMR_S_ON);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pwm_q <= 1'b0;
        else
            pwm_q <= pwm_d;
    end

    // Outside sensor mode, window start doubles as the zero-crossing sampling strobe
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            zstrobe_q <= 1'b0;
        else
            zstrobe_q <= per_wrap && !sensor_mode_sel_q;
    end

    assign drive_pwm = pwm_q;
    assign current_limit_event = limit_evt;
    assign zero_sample_strobe = zstrobe_q;
    assign amp_enable = amp_enable_q;
    assign comparator_input_select = comparator_input_select_q;

endmodule : cmr_regulator

// ==== design/cmr_tick_gen.sv ====
// Enable pulses: 4 MHz time base, peripheral clock and sample strobe.
// Assumes one pclk domain; all outputs are one-cycle pulses, except base_tick, which stays high when TICK_DIV is 1.
`timescale 1ns/1ns
module cmr_tick_gen
#(
    parameter int unsigned TICK_DIV = cmr_pkg::BASE_DIV
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Configuration
    input wire logic fast_sel,
    // Enables
    output logic base_tick,
    output logic sample_en
);
    import cmr_pkg::*;

    logic [7:0] div_q;
    logic [PER_AW-1:0] acc_q;
    logic [PER_AW-1:0] acc_sum;
    logic [1:0] smp_q;
    logic per_en;

    // Time base stays at 4 MHz so durations keep their length
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_q <= 8'h00;
        else if (div_q == 8'(TICK_DIV - 1))
            div_q <= 8'h00;
        else
            div_q <= div_q + 8'h01;
    end

    assign base_tick = (div_q == 8'(TICK_DIV - 1));

    // 8 MHz is not an integer fraction of pclk: accumulator averages it
    assign acc_sum = acc_q + (fast_sel ? PER_AW'(PER_STEP_FAST)
                                       : PER_AW'(PER_STEP_SLOW));
    assign per_en = (acc_sum >= PER_AW'(PER_MOD));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            acc_q <= '0;
        else if (per_en)
            acc_q <= acc_sum - PER_AW'(PER_MOD);
        else
            acc_q <= acc_sum;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            smp_q <= 2'h0;
        else if (per_en)
            smp_q <= smp_q + 2'h1;
    end

    assign sample_en = per_en && (smp_q == 2'(SAMPLE_DIV - 1));

endmodule : cmr_tick_gen

// ==== tb/cmr_regulator_assertions.sv ====
// Port-level assertions on the current-mode PWM regulator.
// Bound to cmr_regulator; sees only its ports.
`timescale 1ns/1ns
module cmr_regulator_assertions
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pslverr,
    // Comparator and PWM
    input wire logic comp_amp_hi,
    input wire logic comp_direct_hi,
    input wire logic voltage_pwm_in,
    input wire logic drive_pwm,
    input wire logic current_limit_event,
    input wire logic zero_sample_strobe,
    input wire logic amp_enable,
    input wire logic comparator_input_select
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Samples are never closer than nine cycles
    sequence s_evt_quiet;
        !current_limit_event [*8];
    endsequence
    sequence s_strobe_quiet;
        !zero_sample_strobe [*8];
    endsequence

    chk_evt_spacing:
        assert property (current_limit_event |=> s_evt_quiet)
        else $error("Limit events too close together");
    chk_evt_cuts_pwm:
        assert property (current_limit_event && !voltage_pwm_in |=> !drive_pwm)
        else $error("PWM still on after limit event");
    chk_evt_cause:
        assert property (current_limit_event |->
        $past(comparator_input_select ? comp_direct_hi : comp_amp_hi))
        else $error("Limit event without selected comparator high");
    chk_strobe_spacing:
        assert property (zero_sample_strobe |=> s_strobe_quiet)
        else $error("Window strobes too close together");
    chk_sel_by_write:
        assert property ($changed(comparator_input_select)
        |-> $past(psel && penable && pwrite))
        else $error("Input select changed without a write");
    chk_amp_by_write:
        assert property ($changed(amp_enable)
        |-> $past(psel && penable && pwrite))
        else $error("Amplifier enable changed without a write");
    chk_err_access:
        assert property (pslverr |-> psel && penable)
        else $error("Slave error outside an access cycle");
    chk_reset_quiet:
        assert property ($rose(presetn) |-> !drive_pwm && !amp_enable
        && !comparator_input_select)
        else $error("Outputs active right after reset");
endmodule : cmr_regulator_assertions

bind cmr_regulator cmr_regulator_assertions u_chk (.pclk, .presetn,
    .psel, .penable, .pwrite, .pslverr, .comp_amp_hi, .comp_direct_hi,
    .voltage_pwm_in, .drive_pwm, .current_limit_event,
    .zero_sample_strobe, .amp_enable, .comparator_input_select);

// ==== tb/cmr_stage_model.sv ====
// Power stage and current sense comparator seen by the regulator.
// Assumes the coil current ramps one step per pclk while driven.
`timescale 1ns/1ns
module cmr_stage_model
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Drive and sense setup
    input wire logic drive_pwm,
    input wire logic [15:0] trip_level,
    input wire logic feed_via_amp,
    // Comparator results
    output logic comp_amp_hi,
    output logic comp_direct_hi
);
    logic [15:0] coil_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            coil_q <= 16'h0000;
        else if (drive_pwm && coil_q != 16'hFFFF)
            coil_q <= coil_q + 16'h0001;
        else if (!drive_pwm && coil_q != 16'h0000)
            coil_q <= coil_q - 16'h0001;
    end

    // Only the pin wired to the sensed current trips; the other idles low
    assign comp_amp_hi = feed_via_amp && coil_q >= trip_level;
    assign comp_direct_hi = !feed_via_amp && coil_q >= trip_level;
endmodule : cmr_stage_model

// ==== tb/current_mode_pwm_regulator_bench.sv ====
// Self-checking bench for the current-mode PWM regulator.
// Assumes TICK_DIV of 1, so durations count plain pclk cycles.
`timescale 1ns/1ns
module current_mode_pwm_regulator_bench;
    import cmr_pkg::*;
    localparam int LIMIT = 90000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic voltage_pwm_in = 1'b0;
    logic feed_via_amp = 1'b1;
    logic [15:0] trip_level = 16'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, drive_pwm, current_limit_event;
    logic zero_sample_strobe, amp_enable, comparator_input_select;
    logic comp_amp_hi, comp_direct_hi;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int ev_cnt = 0;
    int n;
    int s;
    int per_tab [16] = '{80, 100, 120, 160, 200, 221, 260, 320, 400, 640,
        1278, 2564, 3200, 4162, 6400, 10256};

    cmr_regulator #(.TICK_DIV(1)) u_dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .comp_amp_hi, .comp_direct_hi, .voltage_pwm_in, .drive_pwm,
        .current_limit_event, .zero_sample_strobe, .amp_enable,
        .comparator_input_select);
    cmr_stage_model u_stage (.pclk, .presetn, .drive_pwm, .trip_level,
        .feed_via_amp, .comp_amp_hi, .comp_direct_hi);

    always #25 pclk = ~pclk;

    task automatic give_verdict();
        if (bad_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (current_limit_event === 1'b1)
            ev_cnt <= ev_cnt + 1;
        if (cyc == LIMIT)
        begin
            bad_count = bad_count + 1;
            give_verdict();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, exp);
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Clear the hit count, then time the trip to the limit event
    task automatic lat(output int k);
        trip_level <= 16'hFFFF;
        repeat (30) @(posedge pclk);
        trip_level <= 16'h0000;
        k = 0;
        do
        begin
            @(posedge pclk);
            k = k + 1;
        end while (current_limit_event !== 1'b1 && k < 400);
    endtask : lat

    // One window of 80 cycles, after one to settle
    task automatic lows(output int k);
        k = 0;
        repeat (80) @(posedge pclk);
        repeat (80)
        begin
            @(posedge pclk);
            k = k + (drive_pwm === 1'b0);
        end
    endtask : lows

    task automatic per(output int k);
        k = 0;
        do
        begin
            @(posedge pclk);
            k = k + 1;
        end while (zero_sample_strobe !== 1'b1 && k < 11000);
        k = 0;
        do
        begin
            @(posedge pclk);
            k = k + 1;
        end while (zero_sample_strobe !== 1'b1 && k < 11000);
    endtask : per

    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (60) @(posedge pclk);
        check("gated events", ev_cnt, 0);
        apb(1'b0, OFS_FILTER, 32'h0);
        check("filter reset", rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped err", err, 1'b1);
        apb(1'b1, OFS_FILTER, 32'h77);
        apb(1'b0, OFS_FILTER, 32'h0);
        check("filter rw", rd, 32'h77);
        apb(1'b1, OFS_FILTER, 32'h0);
        apb(1'b1, OFS_CTRL_C, 32'h1);
        apb(1'b1, OFS_AMP, 32'h1);
        apb(1'b1, OFS_CTRL_A, 32'h5);
        lat(n);
        check("single hit", n >= 1 && n <= 22, 1'b1);
        for (int c = 1; c < 9; c++)
        begin
            s = (c == 8) ? 10 : 20;
            if (c == 8)
                apb(1'b1, OFS_CONFIG, 32'h20);
            apb(1'b1, OFS_FILTER, 32'((c % 8) << 4));
            lat(n);
            check("hit count", n > (c % 8) * s && n <= (c % 8 + 1) * s + 2,
                1'b1);
        end
        apb(1'b1, OFS_CONFIG, 32'h0);
        feed_via_amp <= 1'b0;
        repeat (3) @(posedge pclk);
        n = ev_cnt;
        repeat (60) @(posedge pclk);
        check("wrong input", ev_cnt - n, 0);
        apb(1'b1, OFS_REF, 32'h1);
        n = ev_cnt;
        repeat (60) @(posedge pclk);
        check("direct input", ev_cnt > n, 1'b1);
        check("select port", comparator_input_select, 1'b1);
        trip_level <= 16'hFFFF;
        apb(1'b1, OFS_CTRL_A, 32'h1);
        voltage_pwm_in <= 1'b1;
        repeat (3) @(posedge pclk);
        check("voltage on", drive_pwm, 1'b1);
        voltage_pwm_in <= 1'b0;
        repeat (3) @(posedge pclk);
        check("voltage off", drive_pwm, 1'b0);
        apb(1'b1, OFS_CTRL_C, 32'h0);
        apb(1'b1, OFS_CTRL_A, 32'h5);
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, OFS_PWM_EN, (c == 7) ? 32'hF : 32'(c));
            lows(n);
            check("off time", n, (c == 7) ? 0 : 10 * (c + 1));
        end
        apb(1'b1, OFS_PWM_EN, 32'h3);
        apb(1'b1, OFS_CTRL_C, 32'h2);
        lows(n);
        check("on-time detect", n, 0);
        apb(1'b1, OFS_CTRL_C, 32'h0);
        apb(1'b1, OFS_CONFIG, 32'h1);
        lows(n);
        check("zero delay", n, 0);
        for (int c = 0; c < 16; c++)
        begin
            apb(1'b1, OFS_PRESC, 32'(c));
            per(n);
            check("window period", n, per_tab[c]);
        end
        give_verdict();
    end
endmodule : current_mode_pwm_regulator_bench
